// [core/speed_torque_command_conditioning.sv]
`timescale 1ns/1ps
// Function
// RULE_01: Speed rises at programmed acceleration time per 1000 r/min, range 0 to 10000.
// RULE_02: Speed falls toward zero at programmed deceleration time per 1000 r/min.
// RULE_03: Ramp time equals target over 1000 times setting, in milliseconds.
// RULE_04: S-curve of programmed width rounds ramp corners, centred on each inflection.
// RULE_05: Zero clamp selection 0 ignores the zero clamp input.
// RULE_06: Selection 1 forces speed command to zero while the clamp is active.
// RULE_07: Selection 2 forces zero, then position hold once speed at or below level.
// RULE_08: Selection 3 holds position when clamp active and speed below level minus 10.
// RULE_09: Selection 3 speed detection uses a 10 r/min hysteresis band.
// RULE_10: Zero clamp level accepts 10 to 20000 r/min, defaulting to 30.
// RULE_11: Zero clamp input is break contact by default: active while terminal open.
// RULE_12: Torque source 0: primary analog torque, speed limit from first value.
// RULE_13: Torque source 1: secondary analog torque, speed limit from primary input.
// RULE_14: Torque source 2: primary analog torque, limit from two per-direction values.
// RULE_15: Velocity/torque mode 5 takes torque from the secondary 12-bit input.
// RULE_16: Direction selection 0: torque command sign gives direction.
// RULE_17: Direction selection 1: torque sign input inactive positive, active negative.
// RULE_18: Source 2 uses first limit for positive, second for negative direction.
// RULE_19: Zero acceleration or deceleration setting passes the command straight through.
module speed_torque_command_conditioning
    import cmd_cond_pkg::*;
#(
    parameter int SCURVE_W = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic signed [15:0] speed_cmd_i,
    input wire logic signed [15:0] actual_speed_i,
    input wire logic [13:0] accel_time_setting_i,
    input wire logic [13:0] decel_time_setting_i,
    input wire logic [SCURVE_W-1:0] scurve_time_i,
    input wire logic zero_clamp_input_i,
    input wire logic zero_clamp_make_contact_i,
    input wire logic [1:0] zero_clamp_select_i,
    input wire logic [14:0] zero_clamp_level_i,
    input wire logic signed [15:0] analog_in_primary_i,
    input wire logic signed [11:0] analog_in_secondary_i,
    input wire logic [1:0] torque_source_select_i,
    input wire logic torque_direction_select_i,
    input wire logic torque_sign_input_i,
    input wire logic [14:0] speed_limit_first_i,
    input wire logic [14:0] speed_limit_second_i,
    input wire logic [3:0] control_mode_setting_i,
    output logic signed [15:0] speed_cmd_o,
    output logic position_hold_o,
    output logic clamp_active_o,
    output logic signed [15:0] torque_cmd_o,
    output logic torque_dir_neg_o,
    output logic [15:0] speed_limit_o
);
    zc_state_t zc_ff, nxt_zc;
    logic signed [15:0] ramp_ff, nxt_ramp;
    logic [RAMP_CNT_W-1:0] ramp_cnt_ff, nxt_ramp_cnt;
    logic [SC_CNT_W-1:0] sc_cnt_ff;
    logic signed [15:0] tap_ff [SC_TAPS];
    logic signed [19:0] sum_ff;

    // Zero clamp decode
    wire clamp_on = zero_clamp_make_contact_i ? zero_clamp_input_i : ~zero_clamp_input_i; // [RULE_11]
    wire level_ok = zero_clamp_level_i >= ZC_LEVEL_MIN && zero_clamp_level_i <= ZC_LEVEL_MAX;
    wire [14:0] zc_level = level_ok ? zero_clamp_level_i : ZC_LEVEL_DFLT; // [RULE_10]
    wire [15:0] act_abs = actual_speed_i[15] ? 16'(-actual_speed_i) : 16'(actual_speed_i);
    wire at_level = act_abs <= {1'b0, zc_level};
    wire below_hys = act_abs < {1'b0, zc_level - ZC_HYST_RPM};
    wire sel_off = zero_clamp_select_i == ZC_SEL_OFF;
    wire sel_force = zero_clamp_select_i == ZC_SEL_FORCE;
    wire sel_hold = zero_clamp_select_i == ZC_SEL_HOLD;
    wire sel_hyst = zero_clamp_select_i == ZC_SEL_HYST;

    always_comb begin
        nxt_zc = zc_ff;
        unique case (zc_ff)
            ZC_FREE: begin
                if (clamp_on && (sel_force || sel_hold)) begin
                    nxt_zc = ZC_FORCE; // [RULE_06]
                end else if (clamp_on && sel_hyst && below_hys) begin
                    nxt_zc = ZC_HOLD; // [RULE_08]
                end
            end
            ZC_FORCE: begin
                if (!clamp_on || sel_off || sel_hyst) begin
                    nxt_zc = ZC_FREE; // [RULE_05]
                end else if (sel_hold && at_level) begin
                    nxt_zc = ZC_HOLD; // [RULE_07]
                end
            end
            ZC_HOLD: begin
                // Mode 3 keeps the hold until speed climbs above the level itself or the clamp releases
                if (clamp_on && sel_force) begin
                    // Selection 1 keeps the command at zero but drops the shaft lock
                    nxt_zc = ZC_FORCE; // [RULE_06]
                end else if (!clamp_on || sel_off || sel_force || (sel_hyst && !at_level)) begin
                    nxt_zc = ZC_FREE; // [RULE_09]
                end
            end
        endcase
    end

    // Ramp generator: one r/min step every setting microseconds
    wire signed [15:0] target = (zc_ff != ZC_FREE) ? 16'sh0000 : speed_cmd_i; // [RULE_06] [RULE_07]
    wire toward_zero = (ramp_ff > 0 && target < ramp_ff) || (ramp_ff < 0 && target > ramp_ff);
    wire [13:0] accel_set = accel_time_setting_i > RAMP_SET_MAX ? RAMP_SET_MAX : accel_time_setting_i;
    wire [13:0] decel_set = decel_time_setting_i > RAMP_SET_MAX ? RAMP_SET_MAX : decel_time_setting_i;
    wire [13:0] ramp_set = toward_zero ? decel_set : accel_set; // [RULE_02]
    wire [RAMP_CNT_W-1:0] step_cyc = RAMP_CNT_W'(ramp_set * US_PER_RPM_PER_MS * CYC_PER_US); // [RULE_03]
    wire at_target = ramp_ff == target;
    wire step_due = ramp_cnt_ff >= step_cyc - RAMP_CNT_W'(1);
    wire step_up = target > ramp_ff;

    always_comb begin
        nxt_ramp = ramp_ff;
        nxt_ramp_cnt = ramp_cnt_ff + RAMP_CNT_W'(1);
        if (ramp_set == 14'h0000) begin
            nxt_ramp = target; // [RULE_19]
            nxt_ramp_cnt = '0;
        end else if (at_target) begin
            nxt_ramp_cnt = '0;
        end else if (step_due) begin
            nxt_ramp = step_up ? ramp_ff + 16'sh0001 : ramp_ff - 16'sh0001; // [RULE_01] [RULE_02]
            nxt_ramp_cnt = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            zc_ff <= ZC_FREE;
            ramp_ff <= '0;
            ramp_cnt_ff <= '0;
        end else begin
            zc_ff <= nxt_zc;
            ramp_ff <= nxt_ramp;
            ramp_cnt_ff <= nxt_ramp_cnt;
        end
    end

    // S-curve: moving average spreads each ramp corner evenly about its centre.
    // Bypassed width samples every cycle so the taps stay current for a later enable.
    wire sc_bypass = scurve_time_i == '0;
    wire [SC_CNT_W-1:0] sc_cyc = SC_CNT_W'(scurve_time_i * SC_CYC_PER_MS);
    wire sc_tick = sc_bypass || sc_cnt_ff >= sc_cyc - SC_CNT_W'(1);
    wire signed [19:0] nxt_sum = sum_ff + 20'(ramp_ff) - 20'(tap_ff[SC_TAPS-1]);
    wire signed [15:0] sc_out = 16'(nxt_sum >>> SC_SHIFT);

    genvar gi;
    generate
        for (gi = 0; gi < SC_TAPS; gi++) begin : g_tap
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    tap_ff[gi] <= '0;
                end else if (sc_tick) begin
                    tap_ff[gi] <= (gi == 0) ? ramp_ff : tap_ff[(gi == 0) ? 0 : gi - 1]; // [RULE_04]
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sc_cnt_ff <= '0;
            sum_ff <= '0;
        end else begin
            sc_cnt_ff <= sc_tick ? '0 : sc_cnt_ff + SC_CNT_W'(1);
            sum_ff <= sc_tick ? nxt_sum : sum_ff;
        end
    end

    // Torque source, direction and speed limit
    wire use_sec = torque_source_select_i == TQ_SEL_SEC || control_mode_setting_i == MODE_VEL_TORQUE; // [RULE_15]
    wire signed [15:0] sec_scaled = {analog_in_secondary_i, 4'h0};
    wire signed [15:0] nxt_torque = use_sec ? sec_scaled : analog_in_primary_i; // [RULE_12] [RULE_13] [RULE_14]
    wire nxt_dir_neg = torque_direction_select_i ? torque_sign_input_i : nxt_torque[15]; // [RULE_16] [RULE_17]
    wire [15:0] pri_abs = analog_in_primary_i[15] ? 16'(-analog_in_primary_i) : 16'(analog_in_primary_i);
    wire limit_zero = clamp_on && !sel_off && torque_source_select_i != TQ_SEL_SEC;
    wire [14:0] dual_lim = nxt_dir_neg ? speed_limit_second_i : speed_limit_first_i; // [RULE_18]
    wire [15:0] nxt_limit = limit_zero ? 16'h0000 :
        torque_source_select_i == TQ_SEL_SEC ? pri_abs : // [RULE_13]
        torque_source_select_i == TQ_SEL_DUAL ? {1'b0, dual_lim} : {1'b0, speed_limit_first_i}; // [RULE_12]

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            speed_cmd_o <= '0;
            position_hold_o <= 1'b0;
            clamp_active_o <= 1'b0;
            torque_cmd_o <= '0;
            torque_dir_neg_o <= 1'b0;
            speed_limit_o <= '0;
        end else begin
            speed_cmd_o <= sc_bypass ? ramp_ff : (sc_tick ? sc_out : speed_cmd_o);
            position_hold_o <= zc_ff == ZC_HOLD;
            clamp_active_o <= clamp_on && !sel_off; // [RULE_05]
            torque_cmd_o <= nxt_torque;
            torque_dir_neg_o <= nxt_dir_neg;
            speed_limit_o <= nxt_limit;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_ramp_bypass: assert property (ramp_set == 14'h0000 |=> ramp_ff == $past(target)) // [RULE_19]
        else $error("zero ramp setting did not pass command through");
    a_ramp_unit_step: assert property (ramp_set != 14'h0000 && !at_target |=>
        (ramp_ff - $past(ramp_ff)) inside {-16'sh0001, 16'sh0000, 16'sh0001}) // [RULE_01]
        else $error("ramp moved by more than one r/min");
    a_ramp_spacing: assert property ($changed(ramp_ff) && $stable(ramp_set) && ramp_set != 14'h0000
        && $stable(target) |=> $stable(ramp_ff)[*8]) // [RULE_03]
        else $error("ramp steps closer than the programmed interval");
    a_decel_dir: assert property (toward_zero && ramp_set != 14'h0000 && step_due && ramp_ff > 0 |=>
        ramp_ff == $past(ramp_ff) - 16'sh0001) // [RULE_02]
        else $error("deceleration did not step toward zero");
    a_zc_ignored: assert property (sel_off [*2] |-> zc_ff == ZC_FREE ##1 !position_hold_o) // [RULE_05]
        else $error("zero clamp acted with selection off");
    a_force_zero: assert property ((clamp_on && sel_force) [*2] |-> target == 16'sh0000) // [RULE_06]
        else $error("clamped speed target not zero");
    a_hold_mode2: assert property (zc_ff == ZC_FORCE && clamp_on && sel_hold && at_level |=>
        ##1 position_hold_o) // [RULE_07]
        else $error("mode 2 did not enter position hold at level");
    a_hold_mode3: assert property (zc_ff == ZC_FREE && clamp_on && sel_hyst && below_hys |=>
        ##1 position_hold_o) // [RULE_08]
        else $error("mode 3 did not enter position hold below band");
    a_hyst_keep: assert property (zc_ff == ZC_HOLD && clamp_on && sel_hyst && at_level |=>
        zc_ff == ZC_HOLD) // [RULE_09]
        else $error("mode 3 hold dropped inside hysteresis band");
    a_torque_sec: assert property (control_mode_setting_i == MODE_VEL_TORQUE |=>
        torque_cmd_o == {$past(analog_in_secondary_i), 4'h0}) // [RULE_15]
        else $error("mode 5 torque not from secondary input");
    a_dir_input: assert property (torque_direction_select_i |=>
        torque_dir_neg_o == $past(torque_sign_input_i)) // [RULE_17]
        else $error("torque direction not from sign input");
    a_limit_dual: assert property (torque_source_select_i == TQ_SEL_DUAL && !limit_zero && nxt_dir_neg |=>
        speed_limit_o == {1'b0, $past(speed_limit_second_i)}) // [RULE_18]
        else $error("negative direction limit not second value");

    // Checks of outputs and zero clamp state against the selection, level and S-curve width inputs
    a_clamp_off_sel: assert property ( // [RULE_05]
        sel_off
        |=> !clamp_active_o)
        else $error("clamp reported active with selection off");
    a_clamp_break: assert property ( // [RULE_11]
        !zero_clamp_make_contact_i && !zero_clamp_input_i && !sel_off
        |=> clamp_active_o)
        else $error("open terminal did not activate clamp");
    a_clamp_make: assert property ( // [RULE_11]
        zero_clamp_make_contact_i && zero_clamp_input_i && !sel_off
        |=> clamp_active_o)
        else $error("closed terminal did not activate clamp in make mode");
    a_level_dflt: assert property ( // [RULE_10]
        zc_ff == ZC_FORCE && clamp_on && sel_hold && !level_ok && act_abs <= {1'b0, ZC_LEVEL_DFLT}
        |=> zc_ff == ZC_HOLD)
        else $error("out of range level did not fall back to default");
    a_mode3_wait: assert property ( // [RULE_08]
        zc_ff == ZC_FREE && sel_hyst && !below_hys
        |=> zc_ff != ZC_HOLD)
        else $error("mode 3 held position above the band");
    a_hold_release: assert property ( // [RULE_07]
        zc_ff == ZC_HOLD && !clamp_on
        |=> zc_ff == ZC_FREE)
        else $error("hold kept after clamp released");
    a_force_keep: assert property ( // [RULE_06]
        zc_ff == ZC_FORCE && clamp_on && sel_force
        |=> zc_ff == ZC_FORCE)
        else $error("forced zero dropped while clamp active");
    a_torque_pri: assert property ( // [RULE_12]
        torque_source_select_i == TQ_SEL_PRI && control_mode_setting_i != MODE_VEL_TORQUE
        |=> torque_cmd_o == $past(analog_in_primary_i))
        else $error("source 0 torque not from primary input");
    a_torque_src1: assert property ( // [RULE_13]
        torque_source_select_i == TQ_SEL_SEC
        |=> torque_cmd_o == {$past(analog_in_secondary_i), 4'h0})
        else $error("source 1 torque not from secondary input");
    a_torque_dual: assert property ( // [RULE_14]
        torque_source_select_i == TQ_SEL_DUAL && control_mode_setting_i != MODE_VEL_TORQUE
        |=> torque_cmd_o == $past(analog_in_primary_i))
        else $error("source 2 torque not from primary input");
    a_limit_first: assert property ( // [RULE_12]
        torque_source_select_i == TQ_SEL_PRI && (sel_off || !clamp_on)
        |=> speed_limit_o == {1'b0, $past(speed_limit_first_i)})
        else $error("source 0 limit not first value");
    a_limit_analog: assert property ( // [RULE_13]
        torque_source_select_i == TQ_SEL_SEC && !analog_in_primary_i[15]
        |=> speed_limit_o == $past(analog_in_primary_i))
        else $error("source 1 limit not from primary input");
    a_limit_clamp: assert property ( // [RULE_06]
        clamp_on && !sel_off && torque_source_select_i != TQ_SEL_SEC
        |=> speed_limit_o == 16'h0000)
        else $error("speed limit not zero under clamp");
    a_limit_pos: assert property ( // [RULE_18]
        torque_source_select_i == TQ_SEL_DUAL && !limit_zero && !nxt_dir_neg
        |=> speed_limit_o == {1'b0, $past(speed_limit_first_i)})
        else $error("positive direction limit not first value");
    a_dir_sign: assert property ( // [RULE_16]
        !torque_direction_select_i
        |=> torque_dir_neg_o == torque_cmd_o[15])
        else $error("torque direction not from command sign");
    a_scurve_hold: assert property ( // [RULE_04]
        !sc_bypass && !sc_tick
        |=> $stable(speed_cmd_o))
        else $error("S-curve output moved between samples");
    a_scurve_bypass: assert property ( // [RULE_04]
        sc_bypass
        |=> speed_cmd_o == $past(ramp_ff))
        else $error("zero S-curve width did not pass ramp through");

    c_ramp_done: cover property (ramp_set != 14'h0000 && !at_target ##1 at_target);
    c_hold_mode2: cover property (zc_ff == ZC_FORCE ##1 zc_ff == ZC_HOLD);
    c_hold_mode3: cover property (sel_hyst && zc_ff == ZC_HOLD ##1 zc_ff == ZC_FREE);
    c_scurve_tick: cover property (!sc_bypass && sc_tick);
    c_clamp_force: cover property (zc_ff == ZC_FREE ##1 zc_ff == ZC_FORCE);
endmodule

// [core/cmd_cond_pkg.sv]
package cmd_cond_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_PS = 25000;
    localparam int US_PS = 1000000;
    localparam int MS_US = 1000;
    localparam int CYC_PER_US = US_PS / CLK_PERIOD_PS;
    // Ramp setting is ms per 1000 r/min, so one r/min step takes setting microseconds
    localparam int RAMP_REF_RPM = 1000;
    localparam int US_PER_RPM_PER_MS = MS_US / RAMP_REF_RPM;
    localparam int RAMP_CNT_W = 19;
    localparam logic [13:0] RAMP_SET_MAX = 14'h2710;
    // S-curve: moving average of 16 taps spread over the programmed width
    localparam int SC_TAPS = 16;
    localparam int SC_SHIFT = 4;
    localparam int SC_CYC_PER_MS = MS_US * CYC_PER_US / SC_TAPS;
    localparam int SC_CNT_W = 22;
    // Zero clamp
    localparam logic [1:0] ZC_SEL_OFF = 2'h0;
    localparam logic [1:0] ZC_SEL_FORCE = 2'h1;
    localparam logic [1:0] ZC_SEL_HOLD = 2'h2;
    localparam logic [1:0] ZC_SEL_HYST = 2'h3;
    localparam logic [14:0] ZC_LEVEL_DFLT = 15'h001E;
    localparam logic [14:0] ZC_LEVEL_MIN = 15'h000A;
    localparam logic [14:0] ZC_LEVEL_MAX = 15'h4E20;
    localparam logic [14:0] ZC_HYST_RPM = 15'h000A;
    // Torque source and mode
    localparam logic [1:0] TQ_SEL_PRI = 2'h0;
    localparam logic [1:0] TQ_SEL_SEC = 2'h1;
    localparam logic [1:0] TQ_SEL_DUAL = 2'h2;
    localparam logic [3:0] MODE_VEL_TORQUE = 4'h5;
    typedef enum logic [2:0] {
        ZC_FREE = 3'b001,
        ZC_FORCE = 3'b010,
        ZC_HOLD = 3'b100
    } zc_state_t;
endpackage

// [tb/host_model.sv]
`timescale 1ns/1ps
module host_model (
    input wire logic clamp_req_i,
    input wire logic make_contact_i,
    input wire logic sign_req_i,
    output logic zero_clamp_input_o,
    output logic torque_sign_input_o
);
    // Break contact by default: terminal open while the clamp is wanted
    assign zero_clamp_input_o = make_contact_i ? clamp_req_i : !clamp_req_i;
    assign torque_sign_input_o = sign_req_i;
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    import cmd_cond_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic signed [15:0] spd_cmd, act_spd, ai_pri, spd_o, tq_o;
    logic signed [11:0] ai_sec;
    logic [13:0] acc_set, dec_set;
    logic [9:0] sc_time;
    logic [1:0] zc_sel, tq_src;
    logic [14:0] zc_lvl, lim1, lim2;
    logic [3:0] mode;
    logic [15:0] lim_o;
    logic clamp_req, make_contact, sign_req, dir_sel, zc_term, tq_sign, hold_o, clamp_o, neg_o;
    int n_errors = 0;
    int checked = 0;
    always #12.5 core_clk = ~core_clk;
    host_model host (.clamp_req_i(clamp_req), .make_contact_i(make_contact), .sign_req_i(sign_req),
        .zero_clamp_input_o(zc_term), .torque_sign_input_o(tq_sign));
    speed_torque_command_conditioning uut (.core_clk_i(core_clk), .rst_i(rst), .speed_cmd_i(spd_cmd),
        .actual_speed_i(act_spd), .accel_time_setting_i(acc_set), .decel_time_setting_i(dec_set),
        .scurve_time_i(sc_time), .zero_clamp_input_i(zc_term), .zero_clamp_make_contact_i(make_contact),
        .zero_clamp_select_i(zc_sel), .zero_clamp_level_i(zc_lvl), .analog_in_primary_i(ai_pri),
        .analog_in_secondary_i(ai_sec), .torque_source_select_i(tq_src), .torque_direction_select_i(dir_sel),
        .torque_sign_input_i(tq_sign), .speed_limit_first_i(lim1), .speed_limit_second_i(lim2),
        .control_mode_setting_i(mode), .speed_cmd_o(spd_o), .position_hold_o(hold_o),
        .clamp_active_o(clamp_o), .torque_cmd_o(tq_o), .torque_dir_neg_o(neg_o), .speed_limit_o(lim_o));
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_sources;
        logic [15:0] exp_lim;
        for (int s = 0; s < 3; s++) begin
            for (int n = 0; n < 2; n++) begin
                tq_src = s[1:0];
                ai_pri = n ? -16'sh0123 : 16'sh0123;
                wait_n(2);
                exp_lim = (s == 1) ? 16'h0123 : ((s == 2 && n == 1) ? {1'b0, lim2} : {1'b0, lim1});
                chk_val(tq_o, (s == 1) ? {ai_sec, 4'h0} : ai_pri);
                chk_val(lim_o, exp_lim);
            end
        end
        tq_src = TQ_SEL_PRI;
        mode = MODE_VEL_TORQUE;
        wait_n(2);
        chk_val(tq_o, {ai_sec, 4'h0});
        mode = 4'h0;
    endtask
    task automatic t_direction;
        for (int i = 0; i < 4; i++) begin
            dir_sel = i[1];
            ai_pri = i[0] ? -16'sh0200 : 16'sh0200;
            sign_req = !i[0];
            wait_n(2);
            chk_bit(neg_o, i[1] ? !i[0] : i[0]);
            chk_val(tq_o, ai_pri);
        end
        dir_sel = 1'b0;
    endtask
    task automatic t_clamp_force;
        spd_cmd = 16'sd100;
        clamp_req = 1'b1;
        wait_n(4);
        chk_bit(clamp_o, 1'b0);
        chk_val(spd_o, 16'h0064);
        zc_sel = ZC_SEL_FORCE;
        wait_n(4);
        chk_bit(clamp_o, 1'b1);
        chk_val(spd_o, 16'h0000);
        chk_val(lim_o, 16'h0000);
        make_contact = 1'b1;
        wait_n(4);
        chk_val(spd_o, 16'h0000);
        clamp_req = 1'b0;
        wait_n(4);
        chk_val(spd_o, 16'h0064);
        make_contact = 1'b0;
    endtask
    task automatic t_hold;
        zc_sel = ZC_SEL_HOLD;
        clamp_req = 1'b1;
        act_spd = 16'sd31;
        wait_n(4);
        chk_bit(hold_o, 1'b0);
        act_spd = 16'sd30;
        wait_n(4);
        chk_bit(hold_o, 1'b1);
        clamp_req = 1'b0;
        wait_n(4);
        chk_bit(hold_o, 1'b0);
        zc_sel = ZC_SEL_HYST;
        zc_lvl = 15'h0005;
        clamp_req = 1'b1;
        act_spd = 16'sd20;
        wait_n(4);
        chk_bit(hold_o, 1'b0);
        act_spd = 16'sd19;
        wait_n(4);
        chk_bit(hold_o, 1'b1);
        act_spd = 16'sd30;
        wait_n(4);
        chk_bit(hold_o, 1'b1);
        act_spd = 16'sd31;
        wait_n(4);
        chk_bit(hold_o, 1'b0);
        clamp_req = 1'b0;
        zc_sel = ZC_SEL_OFF;
    endtask
    task automatic t_ramp;
        spd_cmd = 16'sd0;
        wait_n(4);
        acc_set = 14'h0001;
        dec_set = 14'h0002;
        spd_cmd = 16'sd10;
        wait_n(200);
        chk_bit(spd_o >= 16'sd4 && spd_o <= 16'sd6, 1'b1);
        wait_n(220);
        chk_val(spd_o, 16'h000A);
        spd_cmd = 16'sd0;
        wait_n(400);
        chk_bit(spd_o >= 16'sd4 && spd_o <= 16'sd6, 1'b1);
        wait_n(440);
        chk_val(spd_o, 16'h0000);
        acc_set = 14'h0000;
        dec_set = 14'h0000;
        spd_cmd = -16'sd7;
        wait_n(3);
        chk_val(spd_o, 16'hFFF9);
    endtask
    task automatic t_scurve;
        spd_cmd = 16'sd0;
        wait_n(20);
        sc_time = 10'h001;
        spd_cmd = 16'sd160;
        wait_n(2400);
        chk_val(spd_o, 16'h0000);
        wait_n(2600);
        chk_val(spd_o, 16'h0014);
        sc_time = 10'h000;
        wait_n(3);
        chk_val(spd_o, 16'h00A0);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        {spd_cmd, act_spd, ai_pri, ai_sec, acc_set, dec_set, sc_time} = '0;
        {zc_sel, tq_src, mode, clamp_req, make_contact, sign_req, dir_sel} = '0;
        zc_lvl = ZC_LEVEL_DFLT;
        lim1 = 15'h0BB8;
        lim2 = 15'h07D0;
        ai_sec = 12'h0AB;
        wait_n(20);
        rst = 1'b0;
        chk_val(spd_o, 16'h0000);
        t_sources();
        t_direction();
        t_clamp_force();
        t_hold();
        t_ramp();
        t_scurve();
        finish_test();
    end
endmodule
